// ### rtl/oscr_pkg.sv
package oscr_pkg;
	localparam logic [15:0] ADDR_OUT_FUNC = 16'h1415;
	localparam logic [15:0] ADDR_ALM_FUNC = 16'h141a;
	localparam logic [15:0] ADDR_MON_SRC = 16'h141b;
	localparam logic [15:0] ADDR_RSVD_A = 16'h141c;
	localparam logic [15:0] ADDR_RSVD_B = 16'h141d;
	localparam logic [15:0] ADDR_CUR_REF = 16'h141e;
	localparam logic [15:0] ADDR_OUT_POL = 16'h141f;
	localparam logic [15:0] ADDR_ALM_POL = 16'h1424;
	localparam logic [15:0] ADDR_RSVD_C = 16'h1425;
	localparam logic [15:0] ADDR_LCD_MODE = 16'h1426;
	localparam logic [15:0] ADDR_LCD_THR = 16'h1427;
	localparam logic [15:0] ADDR_OVL_MODE = 16'h1428;
	localparam logic [15:0] ADDR_OVL_THR = 16'h1429;
	// reset values
	localparam logic [15:0] RST_OUT_FUNC = 16'h0000;
	localparam logic [15:0] RST_ALM_FUNC = 16'h0005;
	localparam logic [15:0] RST_MON_SRC = 16'h0000;
	localparam logic [15:0] RST_CUR_REF = 16'h2710;
	localparam logic [15:0] RST_POL = 16'h0000;
	localparam logic [15:0] RST_MODE = 16'h0000;
	localparam logic [15:0] RST_THR = 16'h0000;
	// value limits
	localparam logic [15:0] CUR_REF_MIN = 16'h07d0;
	localparam logic [15:0] THR_MAX = 16'h4e20;
	localparam logic [15:0] CODE_NONE = 16'h00ff;
	// status vector bit positions
	localparam int ST_RUN = 0;
	localparam int ST_SPD_ON = 1;
	localparam int ST_FRQ_OVR = 2;
	localparam int ST_OLN = 3;
	localparam int ST_PID = 4;
	localparam int ST_ALM = 5;
	localparam int ST_FRQ_SET = 6;
	localparam int ST_LOW_V = 7;
	localparam int ST_RUN_TM = 8;
	localparam int ST_PWR_TM = 9;
	localparam int ST_THERM = 10;
	localparam int ST_ZHZ = 11;
	localparam int ST_FBK = 12;
	localparam int ST_CLD = 13;
	localparam int ST_LG1 = 14;
	localparam int ST_STC = 15;
	localparam int ST_OHW = 16;
	localparam int ST_LCI = 17;
	localparam int ST_RDY = 18;
	localparam int ST_FWD = 19;
	localparam int ST_REV = 20;
	localparam int ST_MJF = 21;
	localparam int ST_WIN_CMP = 22;
	localparam int ST_C58 = 23;
	localparam int ST_C59 = 24;
	localparam int ST_C60 = 25;
	localparam int ST_W = 26;
	// monitor sources
	localparam int MON_W = 9;
	localparam logic [15:0] MON_FREQ = 16'h0000;
	localparam logic [15:0] MON_CUR = 16'h0001;
	localparam logic [15:0] MON_DFREQ = 16'h0003;
	localparam logic [15:0] MON_VOLT = 16'h0004;
	localparam logic [15:0] MON_PWR = 16'h0005;
	localparam logic [15:0] MON_THERM = 16'h0006;
	localparam logic [15:0] MON_RAMP = 16'h0007;
	localparam logic [15:0] MON_DCUR = 16'h0008;
	localparam logic [15:0] MON_HS = 16'h000a;
endpackage

// ### rtl/oscr_func_mux.sv
module oscr_func_mux (
	input wire logic [15:0] code_in,
	input wire logic [oscr_pkg::ST_W-1:0] status_in,
	output logic sel_out,
	output logic valid_out
);
	always_comb begin
		sel_out = 1'b0;
		valid_out = 1'b1;
		unique case (code_in)
			16'h0000: sel_out = status_in[oscr_pkg::ST_RUN];
			16'h0001: sel_out = status_in[oscr_pkg::ST_SPD_ON];
			16'h0002: sel_out = status_in[oscr_pkg::ST_FRQ_OVR];
			16'h0003: sel_out = status_in[oscr_pkg::ST_OLN];
			16'h0004: sel_out = status_in[oscr_pkg::ST_PID];
			16'h0005: sel_out = status_in[oscr_pkg::ST_ALM];
			16'h0006: sel_out = status_in[oscr_pkg::ST_FRQ_SET];
			16'h0009: sel_out = status_in[oscr_pkg::ST_LOW_V];
			16'h000b: sel_out = status_in[oscr_pkg::ST_RUN_TM];
			16'h000c: sel_out = status_in[oscr_pkg::ST_PWR_TM];
			16'h000d: sel_out = status_in[oscr_pkg::ST_THERM];
			16'h0015: sel_out = status_in[oscr_pkg::ST_ZHZ];
			16'h001f: sel_out = status_in[oscr_pkg::ST_FBK];
			16'h0020: sel_out = status_in[oscr_pkg::ST_CLD];
			16'h0021: sel_out = status_in[oscr_pkg::ST_LG1];
			16'h0029: sel_out = status_in[oscr_pkg::ST_STC];
			16'h002a: sel_out = status_in[oscr_pkg::ST_OHW];
			16'h002b: sel_out = status_in[oscr_pkg::ST_LCI];
			16'h0032: sel_out = status_in[oscr_pkg::ST_RDY];
			16'h0033: sel_out = status_in[oscr_pkg::ST_FWD];
			16'h0034: sel_out = status_in[oscr_pkg::ST_REV];
			16'h0035: sel_out = status_in[oscr_pkg::ST_MJF];
			16'h0036: sel_out = status_in[oscr_pkg::ST_WIN_CMP];
			16'h003a: sel_out = status_in[oscr_pkg::ST_C58];
			16'h003b: sel_out = status_in[oscr_pkg::ST_C59];
			16'h003c: sel_out = status_in[oscr_pkg::ST_C60];
			oscr_pkg::CODE_NONE: sel_out = 1'b0;
			default: valid_out = 1'b0;
		endcase
	end
endmodule // oscr_func_mux

// ### rtl/oscr_regs.sv
// Contract
// - output terminal selects one status by code
// - codes 21, 31, 32, 33 supported
// - codes 41-43, 50-54 supported
// - codes 58-60 accepted, 255 unassigned
// - alarm relay uses same code set
// - monitor source selector picks analog value
// - current reference accepts 2000 to 20000
// - output polarity 0 open, 1 closed
// - relay polarity 0 open, 1 closed
// - low current mode 0 always, 1 constant
// - low current threshold accepts 0 to 20000
// - overload mode 0 or 1, threshold 0 to 20000
module oscr_regs (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	input wire logic [15:0] addr_in,
	input wire logic [15:0] wdata_in,
	output logic [15:0] rdata_out,
	output logic rd_valid_out,
	output logic wr_ack_out,
	output logic wr_err_out,
	input wire logic [oscr_pkg::ST_W-1:0] status_in,
	input wire logic const_speed_in,
	input wire logic low_current_raw_in,
	input wire logic overload_raw_in,
	input wire logic [oscr_pkg::MON_W*16-1:0] monitor_sources_in,
	output logic terminal_out,
	output logic relay_out,
	output logic [15:0] monitor_terminal_out,
	output logic low_current_indication_out,
	output logic overload_advance_notice_out,
	output logic [15:0] current_ref_out,
	output logic [15:0] low_current_threshold_out,
	output logic [15:0] overload_threshold_out
);
	logic [15:0] out_func_reg;
	logic [15:0] alm_func_reg;
	logic [15:0] mon_src_reg;
	logic [15:0] cur_ref_reg;
	logic [15:0] out_pol_reg;
	logic [15:0] alm_pol_reg;
	logic [15:0] lcd_mode_reg;
	logic [15:0] lcd_thr_reg;
	logic [15:0] ovl_mode_reg;
	logic [15:0] ovl_thr_reg;
	logic out_sel;
	logic out_ok;
	logic alm_sel;
	logic alm_ok;
	logic wr_ok;
	logic wr_hit;
	logic wr_take;
	logic we_out_func;
	logic we_alm_func;
	logic we_mon_src;
	logic we_cur_ref;
	logic we_out_pol;
	logic we_alm_pol;
	logic we_lcd_mode;
	logic we_lcd_thr;
	logic we_ovl_mode;
	logic we_ovl_thr;
	logic [15:0] rd_next;
	logic [15:0] mon_next;
	logic [15:0] mon_word [oscr_pkg::MON_W];

	genvar gi;
	generate
		for (gi = 0; gi < oscr_pkg::MON_W; gi++) begin : g_mon
			assign mon_word[gi] = monitor_sources_in[gi*16 +: 16];
		end
	endgenerate

	oscr_func_mux u_out_mux (
		.code_in(wdata_in),
		.status_in(status_in),
		.sel_out(),
		.valid_out(out_ok)
	);

	oscr_func_mux u_out_sel (
		.code_in(out_func_reg),
		.status_in(status_in),
		.sel_out(out_sel),
		.valid_out()
	);

	oscr_func_mux u_alm_sel (
		.code_in(alm_func_reg),
		.status_in(status_in),
		.sel_out(alm_sel),
		.valid_out(alm_ok)
	);

	// write value check per address
	always_comb begin
		wr_hit = 1'b1;
		wr_ok = 1'b0;
		unique case (addr_in)
			oscr_pkg::ADDR_OUT_FUNC: wr_ok = out_ok;
			oscr_pkg::ADDR_ALM_FUNC: wr_ok = out_ok;
			oscr_pkg::ADDR_MON_SRC: wr_ok = (wdata_in <= oscr_pkg::MON_HS) &&
				(wdata_in != 16'h0002) && (wdata_in != 16'h0009);
			oscr_pkg::ADDR_CUR_REF: wr_ok = (wdata_in >= oscr_pkg::CUR_REF_MIN) &&
				(wdata_in <= oscr_pkg::THR_MAX);
			oscr_pkg::ADDR_OUT_POL: wr_ok = (wdata_in <= 16'h0001);
			oscr_pkg::ADDR_ALM_POL: wr_ok = (wdata_in <= 16'h0001);
			oscr_pkg::ADDR_LCD_MODE: wr_ok = (wdata_in <= 16'h0001);
			oscr_pkg::ADDR_LCD_THR: wr_ok = (wdata_in <= oscr_pkg::THR_MAX);
			oscr_pkg::ADDR_OVL_MODE: wr_ok = (wdata_in <= 16'h0001);
			oscr_pkg::ADDR_OVL_THR: wr_ok = (wdata_in <= oscr_pkg::THR_MAX);
			default: wr_hit = 1'b0;
		endcase
	end

	assign wr_take = wr_en_in && wr_hit && wr_ok;

	// one write strobe per stored register
	always_comb begin
		we_out_func = 1'b0;
		we_alm_func = 1'b0;
		we_mon_src = 1'b0;
		we_cur_ref = 1'b0;
		we_out_pol = 1'b0;
		we_alm_pol = 1'b0;
		we_lcd_mode = 1'b0;
		we_lcd_thr = 1'b0;
		we_ovl_mode = 1'b0;
		we_ovl_thr = 1'b0;
		if (wr_take) begin
			unique case (addr_in)
				oscr_pkg::ADDR_OUT_FUNC: we_out_func = 1'b1;
				oscr_pkg::ADDR_ALM_FUNC: we_alm_func = 1'b1;
				oscr_pkg::ADDR_MON_SRC: we_mon_src = 1'b1;
				oscr_pkg::ADDR_CUR_REF: we_cur_ref = 1'b1;
				oscr_pkg::ADDR_OUT_POL: we_out_pol = 1'b1;
				oscr_pkg::ADDR_ALM_POL: we_alm_pol = 1'b1;
				oscr_pkg::ADDR_LCD_MODE: we_lcd_mode = 1'b1;
				oscr_pkg::ADDR_LCD_THR: we_lcd_thr = 1'b1;
				oscr_pkg::ADDR_OVL_MODE: we_ovl_mode = 1'b1;
				oscr_pkg::ADDR_OVL_THR: we_ovl_thr = 1'b1;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			out_func_reg <= oscr_pkg::RST_OUT_FUNC;
		end else if (we_out_func) begin
			out_func_reg <= wdata_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			alm_func_reg <= oscr_pkg::RST_ALM_FUNC;
		end else if (we_alm_func) begin
			alm_func_reg <= wdata_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			mon_src_reg <= oscr_pkg::RST_MON_SRC;
		end else if (we_mon_src) begin
			mon_src_reg <= wdata_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cur_ref_reg <= oscr_pkg::RST_CUR_REF;
		end else if (we_cur_ref) begin
			cur_ref_reg <= wdata_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			out_pol_reg <= oscr_pkg::RST_POL;
		end else if (we_out_pol) begin
			out_pol_reg <= wdata_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			alm_pol_reg <= oscr_pkg::RST_POL;
		end else if (we_alm_pol) begin
			alm_pol_reg <= wdata_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			lcd_mode_reg <= oscr_pkg::RST_MODE;
		end else if (we_lcd_mode) begin
			lcd_mode_reg <= wdata_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			lcd_thr_reg <= oscr_pkg::RST_THR;
		end else if (we_lcd_thr) begin
			lcd_thr_reg <= wdata_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ovl_mode_reg <= oscr_pkg::RST_MODE;
		end else if (we_ovl_mode) begin
			ovl_mode_reg <= wdata_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ovl_thr_reg <= oscr_pkg::RST_THR;
		end else if (we_ovl_thr) begin
			ovl_thr_reg <= wdata_in;
		end
	end

	// write answer one cycle after the request
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_ack_out <= 1'b0;
		end else begin
			wr_ack_out <= wr_take;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_err_out <= 1'b0;
		end else begin
			wr_err_out <= wr_en_in && !wr_take;
		end
	end

	always_comb begin
		unique case (addr_in)
			oscr_pkg::ADDR_OUT_FUNC: rd_next = out_func_reg;
			oscr_pkg::ADDR_ALM_FUNC: rd_next = alm_func_reg;
			oscr_pkg::ADDR_MON_SRC: rd_next = mon_src_reg;
			oscr_pkg::ADDR_CUR_REF: rd_next = cur_ref_reg;
			oscr_pkg::ADDR_OUT_POL: rd_next = out_pol_reg;
			oscr_pkg::ADDR_ALM_POL: rd_next = alm_pol_reg;
			oscr_pkg::ADDR_LCD_MODE: rd_next = lcd_mode_reg;
			oscr_pkg::ADDR_LCD_THR: rd_next = lcd_thr_reg;
			oscr_pkg::ADDR_OVL_MODE: rd_next = ovl_mode_reg;
			oscr_pkg::ADDR_OVL_THR: rd_next = ovl_thr_reg;
			default: rd_next = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_valid_out <= 1'b0;
		end else begin
			rd_valid_out <= rd_en_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_out <= 16'h0000;
		end else if (rd_en_in) begin
			rdata_out <= rd_next;
		end
	end

	always_comb begin
		unique case (mon_src_reg)
			oscr_pkg::MON_FREQ: mon_next = mon_word[0];
			oscr_pkg::MON_CUR: mon_next = mon_word[1];
			oscr_pkg::MON_DFREQ: mon_next = mon_word[2];
			oscr_pkg::MON_VOLT: mon_next = mon_word[3];
			oscr_pkg::MON_PWR: mon_next = mon_word[4];
			oscr_pkg::MON_THERM: mon_next = mon_word[5];
			oscr_pkg::MON_RAMP: mon_next = mon_word[6];
			oscr_pkg::MON_DCUR: mon_next = mon_word[7];
			oscr_pkg::MON_HS: mon_next = mon_word[8];
			default: mon_next = 16'h0000;
		endcase
	end

	// registered drive of the physical outputs
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			terminal_out <= 1'b0;
		end else begin
			terminal_out <= out_sel ^ out_pol_reg[0];
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			relay_out <= 1'b0;
		end else begin
			relay_out <= (alm_sel & alm_ok) ^ alm_pol_reg[0];
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			monitor_terminal_out <= 16'h0000;
		end else begin
			monitor_terminal_out <= mon_next;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			low_current_indication_out <= 1'b0;
		end else begin
			low_current_indication_out <= low_current_raw_in &
				(!lcd_mode_reg[0] || const_speed_in);
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			overload_advance_notice_out <= 1'b0;
		end else begin
			overload_advance_notice_out <= overload_raw_in &
				(!ovl_mode_reg[0] || const_speed_in);
		end
	end

	assign current_ref_out = cur_ref_reg;
	assign low_current_threshold_out = lcd_thr_reg;
	assign overload_threshold_out = ovl_thr_reg;
endmodule // oscr_regs

// ### tb/oscr_regs_sva.sv
module oscr_regs_sva (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	input wire logic [15:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic rd_valid_out,
	input wire logic wr_ack_out,
	input wire logic wr_err_out,
	input wire logic low_current_raw_in,
	input wire logic overload_raw_in,
	input wire logic low_current_indication_out,
	input wire logic overload_advance_notice_out,
	input wire logic [15:0] current_ref_out,
	input wire logic [15:0] low_current_threshold_out,
	input wire logic [15:0] overload_threshold_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	logic ref_wr;
	logic ref_ok;
	assign ref_wr = wr_en_in && addr_in == oscr_pkg::ADDR_CUR_REF;
	assign ref_ok = wdata_in >= oscr_pkg::CUR_REF_MIN && wdata_in <= oscr_pkg::THR_MAX;
	a_read_answer: assert property (rd_en_in |=> rd_valid_out)
		else $error("read not answered");
	a_write_answer: assert property (wr_en_in |=> wr_ack_out != wr_err_out)
		else $error("write answer wrong");
	a_reserved_refused: assert property (wr_en_in && (addr_in == oscr_pkg::ADDR_RSVD_A ||
		addr_in == oscr_pkg::ADDR_RSVD_C) |=> wr_err_out && !wr_ack_out)
		else $error("reserved write accepted");
	a_ref_range: assert property (ref_wr && !ref_ok |=> wr_err_out && $stable(current_ref_out))
		else $error("bad reference stored");
	a_ref_take: assert property (ref_wr && ref_ok |=> current_ref_out == $past(wdata_in))
		else $error("reference not stored");
	a_thr_take: assert property (wr_en_in && addr_in == oscr_pkg::ADDR_LCD_THR &&
		wdata_in <= oscr_pkg::THR_MAX |=> low_current_threshold_out == $past(wdata_in))
		else $error("threshold not stored");
	a_lc_gate: assert property (!low_current_raw_in |=> !low_current_indication_out)
		else $error("low current without detector");
	a_ovl_gate: assert property (!overload_raw_in |=> !overload_advance_notice_out)
		else $error("overload without detector");
	a_ovl_thr_take: assert property (wr_en_in && addr_in == oscr_pkg::ADDR_OVL_THR &&
		wdata_in <= oscr_pkg::THR_MAX |=> overload_threshold_out == $past(wdata_in))
		else $error("overload threshold not stored");
	c_ref_write: cover property (ref_wr && ref_ok);
	c_ovl: cover property (overload_advance_notice_out);
	c_refused: cover property (wr_err_out);
	c_lc: cover property (low_current_indication_out);
endmodule // oscr_regs_sva

bind oscr_regs oscr_regs_sva oscr_regs_sva_i (.*);

// ### tb/oscr_host.sv
module oscr_host (
	input wire logic clk_in,
	input wire logic [15:0] rdata_in,
	input wire logic rd_valid_in,
	input wire logic wr_ack_in,
	input wire logic wr_err_in,
	output logic wr_en_out = 1'b0,
	output logic rd_en_out = 1'b0,
	output logic [15:0] addr_out = 16'h0000,
	output logic [15:0] wdata_out = 16'h0000
);
	timeunit 1ns;
	timeprecision 1ns;
	// one-cycle request, answer sampled while it stands after the taking edge
	task automatic xfer(input logic w, input logic [15:0] a, d, output logic [15:0] q,
		output logic [1:0] r);
		@(negedge clk_in);
		wr_en_out = w;
		rd_en_out = !w;
		addr_out = a;
		wdata_out = d;
		@(negedge clk_in);
		q = rdata_in;
		r = {wr_err_in, w ? wr_ack_in : rd_valid_in};
		wr_en_out = 1'b0;
		rd_en_out = 1'b0;
		addr_out = ~a;
		wdata_out = ~d;
		@(negedge clk_in);
	endtask
endmodule // oscr_host

// ### tb/output_signal_config_regs_test.sv
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
	$display("unexpected %s expected %h seen %h", nm, (e), (g)); end end
module output_signal_config_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	int n_errors = 0;
	int n_compared = 0;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic wr_en, rd_en, rd_valid, wr_ack, wr_err, term, relay, lc_ind, ovl_ind;
	logic [15:0] addr, wdata, rdata, mon_out, cref, q;
	logic [1:0] r;
	logic [oscr_pkg::ST_W-1:0] status = '0;
	logic cs = 1'b0;
	logic lc_raw = 1'b0;
	logic ovl_raw = 1'b0;
	logic [oscr_pkg::MON_W*16-1:0] mon;
	logic [15:0] sh [0:21];
	logic [32:0] rows [33] = '{33'h0_1415_0015, 33'h0_1415_0020, 33'h0_1415_0021,
		33'h0_1415_002a, 33'h0_1415_0032, 33'h0_1415_0035, 33'h0_1415_003a, 33'h0_1415_003c,
		33'h1_1415_0007, 33'h1_1415_0100, 33'h0_1415_00ff, 33'h0_141a_000d, 33'h1_141a_000a,
		33'h0_141b_000a, 33'h1_141b_0002, 33'h0_141e_07d0, 33'h1_141e_07cf, 33'h0_141e_4e20,
		33'h1_141e_4e21, 33'h0_141f_0001, 33'h1_141f_0002, 33'h0_1424_0001, 33'h1_141c_0001,
		33'h1_141d_0001, 33'h1_1425_0001, 33'h1_1430_0001, 33'h0_1426_0001, 33'h1_1426_0002,
		33'h0_1427_4e20, 33'h1_1427_4e21, 33'h0_1428_0001, 33'h0_1429_4e20, 33'h1_1429_4e21};
	logic [7:0] codes [26] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h09, 8'h0b,
		8'h0c, 8'h0d, 8'h15, 8'h1f, 8'h20, 8'h21, 8'h29, 8'h2a, 8'h2b, 8'h32, 8'h33, 8'h34,
		8'h35, 8'h36, 8'h3a, 8'h3b, 8'h3c};
	logic [7:0] msrc [9] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0a};
	always #25 clk_in = ~clk_in;
	oscr_host oscr_host_i (.clk_in(clk_in), .rdata_in(rdata), .rd_valid_in(rd_valid),
		.wr_ack_in(wr_ack), .wr_err_in(wr_err), .wr_en_out(wr_en), .rd_en_out(rd_en),
		.addr_out(addr), .wdata_out(wdata));
	oscr_regs oscr_regs_i (.clk_in(clk_in), .rst_in(rst_in), .wr_en_in(wr_en),
		.rd_en_in(rd_en), .addr_in(addr), .wdata_in(wdata), .rdata_out(rdata),
		.rd_valid_out(rd_valid), .wr_ack_out(wr_ack), .wr_err_out(wr_err),
		.status_in(status), .const_speed_in(cs), .low_current_raw_in(lc_raw),
		.overload_raw_in(ovl_raw), .monitor_sources_in(mon), .terminal_out(term),
		.relay_out(relay), .monitor_terminal_out(mon_out), .low_current_indication_out(lc_ind),
		.overload_advance_notice_out(ovl_ind), .current_ref_out(cref),
		.low_current_threshold_out(), .overload_threshold_out());
	task automatic wr(input logic [15:0] a, d, input logic e);
		oscr_host_i.xfer(1'b1, a, d, q, r);
		`CHK("write response", {e, !e}, r)
		if (!e) sh[a - 16'h1415] = d;
	endtask
	task automatic rd(input logic [15:0] a);
		oscr_host_i.xfer(1'b0, a, 16'h0000, q, r);
		`CHK("read response", 2'b01, r)
		`CHK("read data", (a >= 16'h1415 && a <= 16'h142a) ? sh[a - 16'h1415] : 16'h0000, q)
	endtask
	task automatic sweep;
		foreach (sh[i]) sh[i] = 16'h0000;
		sh[5] = oscr_pkg::RST_ALM_FUNC;
		sh[9] = oscr_pkg::RST_CUR_REF;
		for (int a = 16'h1415; a <= 16'h142a; a++) rd(a[15:0]);
	endtask
	task automatic tally_and_finish;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic settle(input logic [4:0] v);
		{cs, lc_raw, ovl_raw} = v[4:2];
		repeat (2) @(negedge clk_in);
		`CHK("detectors", v[1:0], {lc_ind, ovl_ind})
	endtask
	initial begin
		for (int k = 0; k < oscr_pkg::MON_W; k++) mon[k*16+:16] = 16'ha000 + k[15:0];
		repeat (3) @(negedge clk_in);
		rst_in = 1'b0;
		sweep();
		foreach (rows[i]) begin
			wr(rows[i][31:16], rows[i][15:0], rows[i][32]);
			rd(rows[i][31:16]);
		end
		`CHK("unassigned terminal", 2'b11, {term, relay})
		foreach (codes[i]) begin
			wr(16'h1415, {8'h00, codes[i]}, 1'b0);
			wr(16'h141a, {8'h00, codes[i]}, 1'b0);
			status = 26'h1 << i;
			repeat (2) @(negedge clk_in);
			`CHK("selected on", 2'b00, {term, relay})
			status = ~(26'h1 << i);
			repeat (2) @(negedge clk_in);
			`CHK("selected off", 2'b11, {term, relay})
		end
		wr(16'h141f, 16'h0000, 1'b0);
		`CHK("open polarity", 1'b0, term)
		wr(16'h1424, 16'h0000, 1'b0);
		`CHK("open relay", 2'b00, {term, relay})
		foreach (msrc[k]) begin
			wr(16'h141b, {8'h00, msrc[k]}, 1'b0);
			`CHK("monitor word", 16'ha000 + k[15:0], mon_out)
		end
		settle(5'b01100);
		settle(5'b11111);
		wr(16'h1426, 16'h0000, 1'b0);
		wr(16'h1428, 16'h0000, 1'b0);
		settle(5'b01111);
		rst_in = 1'b1;
		@(negedge clk_in);
		`CHK("reset reference", oscr_pkg::RST_CUR_REF, cref)
		rst_in = 1'b0;
		sweep();
		tally_and_finish();
	end
	initial begin
		#200us;
		n_errors++;
		tally_and_finish();
	end
endmodule // output_signal_config_regs_test
